// *** design/dqm_lookup.sv ***
`timescale 1ns/1ps
module dqm_lookup
  import dqm_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire dqm_req_s             req,
  input  wire logic [DQM_MAP_W-1:0] map_five,
  input  wire logic [DQM_MAP_W-1:0] map_six,
  input  wire logic [DQM_MAP_W-1:0] map_seven,
  output dqm_ans_s                  ans
);
  logic [DQM_CODE_W-1:0] code;
  logic [DQM_MAP_W-1:0]  map_sel;
  logic                  hit;

  function automatic logic [1:0] field_of(input logic [15:0] m, input logic [2:0] lo);
    field_of = m[{lo, 1'b0} +: 2];
  endfunction : field_of

  assign code = req.class_octet[DQM_CODE_LSB +: DQM_CODE_W];

  always_comb begin
    hit     = 1'b1;
    map_sel = '0;
    case (code[5:3])
      DQM_HI_FIVE:  map_sel = map_five;
      DQM_HI_SIX:   map_sel = map_six;
      DQM_HI_SEVEN: map_sel = map_seven;
      default:      hit     = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ans <= '0;
    end else begin
      ans.valid <= req.valid;
      ans.hit   <= req.valid & hit;
      ans.queue <= field_of(map_sel, code[2:0]);
    end
  end

  chk_lookup_field: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req.valid && code[5:3] == DQM_HI_SEVEN)
      |=> (ans.hit && ans.queue == $past(map_seven[{code[2:0], 1'b0} +: 2])))
    else $error("seventh map field not selected");
  chk_lookup_miss: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req.valid && code[5:3] < DQM_HI_FIVE) |=> (ans.valid && !ans.hit))
    else $error("lower code reported as hit");
endmodule : dqm_lookup

// *** design/dqm_pkg.sv ***
package dqm_pkg;
  localparam int unsigned DQM_MAP_W     = 16;
  localparam int unsigned DQM_FIELD_W   = 2;
  localparam int unsigned DQM_CODE_W    = 6;
  localparam int unsigned DQM_CODE_LSB  = 2;
  // register indices; byte address is four times the index
  localparam logic [7:0]  DQM_IDX_FIVE  = 8'h71;
  localparam logic [7:0]  DQM_IDX_SIX   = 8'h72;
  localparam logic [7:0]  DQM_IDX_SEVEN = 8'h73;
  localparam logic [15:0] DQM_RST_FIVE  = 16'h0000;
  localparam logic [15:0] DQM_RST_SIX   = 16'h0000;
  localparam logic [15:0] DQM_RST_SEVEN = 16'h0000;
  localparam logic [2:0]  DQM_HI_FIVE   = 3'h5;
  localparam logic [2:0]  DQM_HI_SIX    = 3'h6;
  localparam logic [2:0]  DQM_HI_SEVEN  = 3'h7;
  localparam logic [1:0]  DQM_RESP_OK   = 2'h0;
  localparam logic [1:0]  DQM_RESP_DEC  = 2'h3;

  typedef struct packed {
    logic       valid;
    logic [7:0] class_octet;
  } dqm_req_s;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [1:0] queue;
  } dqm_ans_s;
endpackage : dqm_pkg

// *** design/dqm_top.sv ***
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - codes 101xxx use fifth map register
// - codes 110xxx use sixth register, field 2*low
// - codes 111xxx use seventh map register
// - two-bit fields give one of four queues
// - sixth register at 72h, resets zero
// - all fields read back last written value
module dqm_top
  import dqm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire dqm_req_s    cls_req,
  output dqm_ans_s         cls_ans
);
  logic [DQM_MAP_W-1:0] class_queue_map_five;
  logic [DQM_MAP_W-1:0] class_queue_map_six;
  logic [DQM_MAP_W-1:0] class_queue_map_seven;
  logic                 aw_held;
  logic                 w_held;
  logic [31:0]          aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 do_write;

  function automatic logic [1:0] reg_sel(input logic [31:0] a);
    if (a[1:0] != 2'h0 || a[31:10] != '0)
      reg_sel = 2'h0;
    else if (a[9:2] == DQM_IDX_FIVE)
      reg_sel = 2'h1;
    else if (a[9:2] == DQM_IDX_SIX)
      reg_sel = 2'h2;
    else if (a[9:2] == DQM_IDX_SEVEN)
      reg_sel = 2'h3;
    else
      reg_sel = 2'h0;
  endfunction : reg_sel

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      class_queue_map_five  <= DQM_RST_FIVE;
      class_queue_map_six   <= DQM_RST_SIX;
      class_queue_map_seven <= DQM_RST_SEVEN;
    end else if (do_write) begin
      case (reg_sel(aw_addr))
        2'h1:    class_queue_map_five  <= merge(class_queue_map_five, w_data, w_strb);
        2'h2:    class_queue_map_six   <= merge(class_queue_map_six, w_data, w_strb);
        2'h3:    class_queue_map_seven <= merge(class_queue_map_seven, w_data, w_strb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DQM_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (reg_sel(aw_addr) == 2'h0) ? DQM_RESP_DEC : DQM_RESP_OK;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= DQM_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= DQM_RESP_OK;
      case (reg_sel(s_axi_araddr))
        2'h1:    s_axi_rdata <= {16'h0000, class_queue_map_five};
        2'h2:    s_axi_rdata <= {16'h0000, class_queue_map_six};
        2'h3:    s_axi_rdata <= {16'h0000, class_queue_map_seven};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= DQM_RESP_DEC;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  dqm_lookup u_lookup (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .req       (cls_req),
    .map_five  (class_queue_map_five),
    .map_six   (class_queue_map_six),
    .map_seven (class_queue_map_seven),
    .ans       (cls_ans)
  );

  chk_six_reset: assert property (@(posedge sys_clk)
    $rose(rst_b) |-> class_queue_map_six == 16'h0000)
    else $error("sixth map not zero after reset");
  chk_write_lands: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_write && reg_sel(aw_addr) == 2'h2 && w_strb == 4'hf)
      |=> class_queue_map_six == $past(w_data[15:0]))
    else $error("sixth map write lost");
  chk_read_back: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr) == 2'h1)
      |=> (s_axi_rvalid && s_axi_rdata == {16'h0000, $past(class_queue_map_five)}))
    else $error("fifth map readback wrong");
  chk_six_field: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:5] == 3'h6)
      |=> cls_ans.queue == $past(class_queue_map_six[{cls_req.class_octet[4:2], 1'b0} +: 2]))
    else $error("sixth map field not selected");
  chk_five_top: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:2] == 6'h2f)
      |=> cls_ans.queue == $past(class_queue_map_five[15:14]))
    else $error("code 2f not from bits 15:14");
  chk_seven_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:2] == 6'h38)
      |=> (cls_ans.hit && cls_ans.queue == $past(class_queue_map_seven[1:0])))
    else $error("code 38 not from bits 1:0");
  chk_octet_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:5] == 3'h7 && cls_req.class_octet[4:0] == 5'h03)
      |=> cls_ans.queue == $past(class_queue_map_seven[1:0]))
    else $error("low octet bits affect code");
  chk_write_resp: assert property (@(posedge sys_clk) disable iff (!rst_b)
    do_write |=> (s_axi_bvalid && !s_axi_awready && !s_axi_wready))
    else $error("write response missing");
  chk_five_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_write && reg_sel(aw_addr) == 2'h1 && w_strb == 4'hf)
      |=> class_queue_map_five == $past(w_data[15:0]))
    else $error("fifth map write lost");
  chk_seven_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_write && reg_sel(aw_addr) == 2'h3 && w_strb == 4'hf)
      |=> class_queue_map_seven == $past(w_data[15:0]))
    else $error("seventh map write lost");
  chk_low_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_write && reg_sel(aw_addr) == 2'h2 && w_strb[1:0] == 2'b01)
      |=> class_queue_map_six == {$past(class_queue_map_six[15:8]), $past(w_data[7:0])})
    else $error("sixth map low byte strobe wrong");
  chk_high_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_write && reg_sel(aw_addr) == 2'h2 && w_strb[1:0] == 2'b10)
      |=> class_queue_map_six == {$past(w_data[15:8]), $past(class_queue_map_six[7:0])})
    else $error("sixth map high byte strobe wrong");
  chk_bad_no_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (do_write && reg_sel(aw_addr) == 2'h0)
      |=> ($stable(class_queue_map_five) && $stable(class_queue_map_six)
           && $stable(class_queue_map_seven) && s_axi_bresp == DQM_RESP_DEC))
    else $error("unmapped write changed a map");
  chk_read_six: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr) == 2'h2)
      |=> (s_axi_rvalid && s_axi_rdata == {16'h0000, $past(class_queue_map_six)}))
    else $error("sixth map readback wrong");
  chk_read_seven: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr) == 2'h3)
      |=> (s_axi_rvalid && s_axi_rdata == {16'h0000, $past(class_queue_map_seven)}))
    else $error("seventh map readback wrong");
  chk_read_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_axi_arvalid && s_axi_arready && reg_sel(s_axi_araddr) == 2'h0)
      |=> (s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == DQM_RESP_DEC))
    else $error("unmapped read not refused");
  chk_seven_top: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:2] == 6'h3f)
      |=> (cls_ans.hit && cls_ans.queue == $past(class_queue_map_seven[15:14])))
    else $error("code 3f not from bits 15:14");
  chk_five_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:2] == 6'h28)
      |=> (cls_ans.hit && cls_ans.queue == $past(class_queue_map_five[1:0])))
    else $error("code 28 not from bits 1:0");
  chk_code_3a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:2] == 6'h3a)
      |=> (cls_ans.hit && cls_ans.queue == $past(class_queue_map_seven[5:4])))
    else $error("code 3a not from bits 5:4");
  chk_six_ends: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (cls_req.valid && cls_req.class_octet[7:2] == 6'h37)
      |=> (cls_ans.hit && cls_ans.queue == $past(class_queue_map_six[15:14])))
    else $error("code 37 not from bits 15:14");
endmodule : dqm_top

// *** testbench/dqm_cls_model.sv ***
`timescale 1ns/1ps
module dqm_cls_model
  import dqm_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire dqm_ans_s ans,
  output dqm_req_s      req
);
  initial begin
    req = '0;
  end

  // one request pulse, answer sampled in the cycle after
  task lookup(input logic [7:0] oct, output dqm_ans_s a);
    @(posedge sys_clk);
    req.valid       <= 1'b1;
    req.class_octet <= oct;
    @(posedge sys_clk);
    req.valid       <= 1'b0;
    req.class_octet <= ~oct;
    @(negedge sys_clk);
    a = ans;
  endtask : lookup
endmodule : dqm_cls_model

// *** testbench/dscp_upper_priority_map_test.sv ***
`timescale 1ns/1ps
module dscp_upper_priority_map_test;
  import dqm_pkg::*;
  logic        sys_clk, rst_b, awv, awr, wv, wr, bv, brd, arv, arr, rv, rrd;
  logic [31:0] awa, wd, ara, rdat;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  dqm_req_s    req;
  dqm_ans_s    ans;
  int          err_count, tests_run, cyc;
  localparam logic [31:0] A5 = {22'h0, DQM_IDX_FIVE, 2'b00};
  localparam logic [31:0] A6 = {22'h0, DQM_IDX_SIX, 2'b00};
  localparam logic [31:0] A7 = {22'h0, DQM_IDX_SEVEN, 2'b00};

  dqm_top dqm_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .cls_req(req), .cls_ans(ans));
  dqm_cls_model dqm_cls_model_inst (.sys_clk(sys_clk), .ans(ans), .req(req));

  task give_verdict;
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er,
              input logic [3:0] s);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge sys_clk);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    ws  <= s;
    brd <= 1'b1;
    while (!tb) begin
      @(negedge sys_clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = brd && bv;
      r  = bresp;
      @(posedge sys_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) brd <= 1'b0;
    end
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : axi_wr

  task axi_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tb;
    logic [31:0] d;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge sys_clk);
    arv <= 1'b1;
    ara <= a;
    rrd <= 1'b1;
    while (!tb) begin
      @(negedge sys_clk);
      ta = arv && arr;
      tb = rrd && rv;
      d  = rdat;
      r  = rresp;
      @(posedge sys_clk);
      if (ta) arv <= 1'b0;
      if (tb) rrd <= 1'b0;
    end
    chk("rdata", d, e);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : axi_rd

  // every upper code plus two below range; octet low bits vary and must not matter
  task sweep(input logic [15:0] m5, input logic [15:0] m6, input logic [15:0] m7);
    dqm_ans_s    a;
    logic [15:0] m;
    logic [5:0]  c;
    for (int i = 38; i < 64; i++) begin
      c = i[5:0];
      m = (c[5:3] == 3'h5) ? m5 : (c[5:3] == 3'h6) ? m6 : m7;
      dqm_cls_model_inst.lookup({c, c[1:0]}, a);
      chk("ans_valid", {31'h0, a.valid}, 32'h1);
      chk("hit", {31'h0, a.hit}, {31'h0, (i >= 40)});
      if (i >= 40) begin
        chk("queue", {30'h0, a.queue}, {30'h0, m[2*c[2:0] +: 2]});
      end
    end
  endtask : sweep

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict;
    end
  end

  initial begin
    rst_b = 1'b0;
    awv   = 1'b0;
    wv    = 1'b0;
    brd   = 1'b0;
    arv   = 1'b0;
    rrd   = 1'b0;
    awa   = '0;
    wd    = '0;
    ws    = '0;
    ara   = '0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    axi_rd(A6, 32'h0, DQM_RESP_OK);
    axi_rd(A5, 32'h0, DQM_RESP_OK);
    axi_rd(A7, 32'h0, DQM_RESP_OK);
    sweep(16'h0, 16'h0, 16'h0);
    axi_wr(A5, 32'hffffe4b1, DQM_RESP_OK, 4'hf);
    axi_wr(A6, 32'h5a5a1b4e, DQM_RESP_OK, 4'hf);
    axi_wr(A7, 32'h00009c63, DQM_RESP_OK, 4'hf);
    axi_rd(A5, 32'h0000e4b1, DQM_RESP_OK);
    axi_rd(A6, 32'h00001b4e, DQM_RESP_OK);
    axi_rd(A7, 32'h00009c63, DQM_RESP_OK);
    sweep(16'he4b1, 16'h1b4e, 16'h9c63);
    axi_wr(A6 + 32'h2, 32'h0000ffff, DQM_RESP_DEC, 4'hf);
    axi_rd(32'h00000400, 32'h0, DQM_RESP_DEC);
    axi_rd(A6, 32'h00001b4e, DQM_RESP_OK);
    axi_wr(A6, 32'hffffff77, DQM_RESP_OK, 4'h1);
    axi_rd(A6, 32'h00001b77, DQM_RESP_OK);
    axi_wr(A6, 32'h0000c300, DQM_RESP_OK, 4'ha);
    axi_rd(A6, 32'h0000c377, DQM_RESP_OK);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    axi_rd(A6, 32'h0, DQM_RESP_OK);
    axi_rd(A5, 32'h0, DQM_RESP_OK);
    axi_rd(A7, 32'h0, DQM_RESP_OK);
    sweep(16'h0, 16'h0, 16'h0);
    give_verdict;
  end
endmodule : dscp_upper_priority_map_test
